// File: hw/dtb_pkg.sv
package dtb_pkg;

   // ----------------------------------------------------------------
   // Line widths
   // ----------------------------------------------------------------
   localparam int AD_W  = 32;   // Address / data lines
   localparam int CL_W  = 4;    // Control lines
   localparam int ID_W  = 5;    // Identification lines
   localparam int WA_W  = 30;   // Word address A31-A02
   localparam int AE_W  = 6;    // Address extension AE5-AE0
   localparam int RS_W  = 5;    // Register select RS4-RS0

   // ----------------------------------------------------------------
   // Address-phase control line codes (CL3..CL0)
   // ----------------------------------------------------------------
   localparam logic [1:0] CLHI_TR_A64  = 2'h0;   // CL3:CL2 for transparent 64-bit
   localparam logic [1:0] CLHI_TR_VME  = 2'h3;   // CL3:CL2 for transparent backplane
   localparam logic [3:0] CL_TR_BLA    = 4'h4;   // Transparent byte lane
   localparam logic [3:0] CL_RSVD_5    = 4'h5;   // Reserved
   localparam logic [3:0] CL_RSVD_6    = 4'h6;   // Reserved
   localparam logic [3:0] CL_IACK      = 4'h7;   // Interrupt acknowledge
   localparam logic [3:0] CL_DIR_C     = 4'h8;   // Direct compelled
   localparam logic [3:0] CL_DIR_NC1   = 4'h9;   // Direct non-compelled one
   localparam logic [3:0] CL_DIR_NC2   = 4'hA;   // Direct non-compelled two
   localparam logic [3:0] CL_RSVD_B    = 4'hB;   // Reserved

   // ----------------------------------------------------------------
   // Data-phase field positions
   // ----------------------------------------------------------------
   localparam int CL_BLT_BIT   = 3;   // Block transfer flag
   localparam int CL_WR_BIT    = 2;   // Write direction flag
   localparam int CL_DSEL_HI   = 1;   // Data select, upper bit
   localparam int ID_RSVD_BIT  = 4;   // Reserved ID line in transparent cycles

   // ----------------------------------------------------------------
   // Reset values and special numbers
   // ----------------------------------------------------------------
   localparam logic [4:0]  DN_BCAST     = 5'h00;   // Broadcast / broadcall number
   localparam logic [29:0] WA_RST       = 30'h0000_0000;
   localparam logic [5:0]  AE_RST       = 6'h00;
   localparam logic [4:0]  ID_RST       = 5'h00;

   // Decoded cycle types
   typedef enum logic [2:0]
   {
      CYC_TR_A64  = 3'h0,
      CYC_TR_BLA  = 3'h1,
      CYC_IACK    = 3'h2,
      CYC_DIR_C   = 3'h3,
      CYC_DIR_NC1 = 3'h4,
      CYC_DIR_NC2 = 3'h5,
      CYC_TR_VME  = 3'h6,
      CYC_RSVD    = 3'h7
   } cyc_t;

endpackage

// File: hw/dtb_if.sv
// ----------------------------------------------------------------
// Information lines of the data transfer bus, with phase strobes
// ----------------------------------------------------------------
interface dtb_if;
   logic [31:0] ad;         // Address / data lines
   logic [3:0]  cl;         // Control lines
   logic [4:0]  id;         // Identification lines
   logic        ap_stb;     // Lines hold an address phase this cycle
   logic        dp_stb;     // Lines hold a data transfer this cycle
   logic        cyc_end;    // Current cycle ends this cycle

   // Master end drives the lines
   modport master
   (
      output ad, cl, id, ap_stb, dp_stb, cyc_end
   );

   // Slave end only samples them
   modport slave
   (
      input  ad, cl, id, ap_stb, dp_stb, cyc_end
   );
endinterface

// File: hw/dtb_master_encoder.sv
module dtb_master_encoder
(
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   // User request
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire dtb_pkg::cyc_t     req_type,
   input  wire logic [4:0]        req_num,
   input  wire logic [29:0]       req_waddr,
   input  wire logic [5:0]        req_ae,
   input  wire logic [4:0]        req_rs,
   input  wire logic              req_blt,
   input  wire logic              req_write,
   input  wire logic [1:0]        req_dsel,
   // Outcome
   output logic                   req_err,
   // Bus side
   dtb_if.master                  bus
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      M_IDLE = 2'b00,
      M_DATA = 2'b01
   } mst_t;

   mst_t        st_ff,   nxt_st;      // Sequencer state
   logic [31:0] ad_ff,   nxt_ad;      // Registered line values
   logic [3:0]  cl_ff,   nxt_cl;
   logic [4:0]  id_ff,   nxt_id;
   logic        ap_ff,   nxt_ap;
   logic        dp_ff,   nxt_dp;
   logic        end_ff,  nxt_end;
   logic        err_ff,  nxt_err;
   logic        legal;                // Request may be issued
   logic        wr_eff;               // Direction after forcing
   logic [3:0]  cl_addr;              // Address-phase control code

   assign req_ready   = (st_ff == M_IDLE);
   assign req_err     = err_ff;
   assign bus.ad      = ad_ff;
   assign bus.cl      = cl_ff;
   assign bus.id      = id_ff;
   assign bus.ap_stb  = ap_ff;
   assign bus.dp_stb  = dp_ff;
   assign bus.cyc_end = end_ff;

   // ----------------------------------------------------------------
   // Request checks and field encoding
   // ----------------------------------------------------------------
   // Number zero refused on the second non-compelled type, and on
   // non-compelled one with req_write low; the reserved type never goes out.
   always_comb
   begin
      legal = 1'b1;
      if (req_type == dtb_pkg::CYC_RSVD)
      begin
         legal = 1'b0;
      end
      else if ((req_num == dtb_pkg::DN_BCAST) &&
               ((req_type == dtb_pkg::CYC_DIR_NC2) ||
                ((req_type == dtb_pkg::CYC_DIR_NC1) && !req_write)))
      begin
         legal = 1'b0;
      end
      // Forced direction bits
      case (req_type)
         dtb_pkg::CYC_DIR_NC1: wr_eff = 1'b1;
         dtb_pkg::CYC_IACK:    wr_eff = 1'b0;
         default:              wr_eff = req_write;
      endcase
      // Cycle type onto CL3..CL0, extension bits where the type allows
      case (req_type)
         dtb_pkg::CYC_TR_A64:  cl_addr = {dtb_pkg::CLHI_TR_A64, req_ae[5:4]};
         dtb_pkg::CYC_TR_VME:  cl_addr = {dtb_pkg::CLHI_TR_VME, req_ae[5:4]};
         dtb_pkg::CYC_TR_BLA:  cl_addr = dtb_pkg::CL_TR_BLA;
         dtb_pkg::CYC_IACK:    cl_addr = dtb_pkg::CL_IACK;
         dtb_pkg::CYC_DIR_C:   cl_addr = dtb_pkg::CL_DIR_C;
         dtb_pkg::CYC_DIR_NC1: cl_addr = dtb_pkg::CL_DIR_NC1;
         dtb_pkg::CYC_DIR_NC2: cl_addr = dtb_pkg::CL_DIR_NC2;
         default:              cl_addr = dtb_pkg::CL_RSVD_B;
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencer: one address phase, then one data transfer
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_st  = st_ff;
      nxt_ad  = ad_ff;
      nxt_cl  = cl_ff;
      nxt_id  = id_ff;
      nxt_ap  = 1'b0;
      nxt_dp  = 1'b0;
      nxt_end = 1'b0;
      nxt_err = 1'b0;
      case (st_ff)
         M_IDLE:
         begin
            if (req_valid && !legal)
            begin
               nxt_err = 1'b1;                 // Refused, lines untouched
            end
            else if (req_valid)
            begin
               nxt_ad = {req_waddr, 2'b00};
               nxt_cl = cl_addr;
               nxt_id = req_num;               // Device or interrupter
               nxt_ap = 1'b1;
               nxt_st = M_DATA;
            end
         end
         M_DATA:
         begin
            // Data lines left to the transfer logic; zero here
            nxt_ad  = {dtb_pkg::AD_W{1'b0}};
            nxt_cl  = {req_blt, wr_eff, req_dsel};
            if (req_type == dtb_pkg::CYC_IACK)
            begin
               nxt_cl[dtb_pkg::CL_BLT_BIT] = 1'b0;
               nxt_id = dtb_pkg::ID_RST;
            end
            else if ((req_type == dtb_pkg::CYC_DIR_C) || (req_type == dtb_pkg::CYC_DIR_NC1) ||
                     (req_type == dtb_pkg::CYC_DIR_NC2))
            begin
               nxt_id = req_rs;
            end
            else
            begin
               nxt_id = {1'b0, req_ae[3:0]};
            end
            nxt_dp  = 1'b1;
            nxt_end = 1'b1;
            nxt_st  = M_IDLE;
         end
         default:
         begin
            nxt_st = M_IDLE;
         end
      endcase
   end

   // Register stage only
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_ff  <= M_IDLE;
         ad_ff  <= 32'h0000_0000;
         cl_ff  <= 4'h0;
         id_ff  <= dtb_pkg::ID_RST;
         ap_ff  <= 1'b0;
         dp_ff  <= 1'b0;
         end_ff <= 1'b0;
         err_ff <= 1'b0;
      end
      else
      begin
         st_ff  <= nxt_st;
         ad_ff  <= nxt_ad;
         cl_ff  <= nxt_cl;
         id_ff  <= nxt_id;
         ap_ff  <= nxt_ap;
         dp_ff  <= nxt_dp;
         end_ff <= nxt_end;
         err_ff <= nxt_err;
      end
   end

endmodule

// File: hw/dtb_slave_decoder.sv
module dtb_slave_decoder
(
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   // Configuration
   input  wire logic [4:0]        dn_switch,
   input  wire logic              bcast_en,
   input  wire logic              map_en,
   input  wire logic [7:0]        map_base,
   // Bus side
   dtb_if.slave                   bus,
   // Address-phase results
   output logic                   ap_done,
   output dtb_pkg::cyc_t          cyc_type,
   output logic [4:0]             num,
   output logic                   sel_single,
   output logic                   sel_bcast,
   output logic                   selected,
   output logic [29:0]            word_addr,
   // Data-phase results
   output logic                   dp_done,
   output logic [5:0]             ae,
   output logic [4:0]             rs,
   output logic                   blt,
   output logic                   write,
   output logic [1:0]             dsel,
   // Front panel
   output logic [4:0]             dn_shown
);

   // ----------------------------------------------------------------
   // State and registers
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      S_IDLE = 2'b00,   // Waiting for an address phase
      S_SEL  = 2'b01,   // Selected, decoding data transfers
      S_SKIP = 2'b10    // Not selected, waiting for cycle end
   } slv_t;

   slv_t          st_ff,     nxt_st;       // Cycle tracker
   dtb_pkg::cyc_t typ_ff,    nxt_typ;      // Decoded cycle type
   logic [4:0]    num_ff,    nxt_num;      // Device or interrupter number
   logic          single_ff, nxt_single;   // Individually selected
   logic          bcast_ff,  nxt_bcast;    // Selected by number zero
   logic [29:0]   wa_ff,     nxt_wa;       // Word address
   logic [5:0]    ae_ff,     nxt_ae;       // Full extension field
   logic [4:0]    rs_ff,     nxt_rs;       // Register select
   logic          blt_ff,    nxt_blt;
   logic          wr_ff,     nxt_wr;
   logic [1:0]    dsel_ff,   nxt_dsel;
   logic          apd_ff,    nxt_apd;      // Address phase taken pulse
   logic          dpd_ff,    nxt_dpd;      // Data transfer taken pulse
   logic [4:0]    dn_ff,     nxt_dn;       // Number in use, sampled from switches
   dtb_pkg::cyc_t typ_dec;                 // Type decoded from live lines
   logic          bc_able;                 // Type may be broadcast
   logic          is_direct;               // Captured cycle type is direct

   assign ap_done    = apd_ff;
   assign dp_done    = dpd_ff;
   assign cyc_type   = typ_ff;
   assign num        = num_ff;
   assign sel_single = single_ff;
   assign sel_bcast  = bcast_ff;
   assign selected   = single_ff | bcast_ff;
   assign word_addr  = wa_ff;
   assign ae         = ae_ff;
   assign rs         = rs_ff;
   assign blt        = blt_ff;
   assign write      = wr_ff;
   assign dsel       = dsel_ff;
   assign dn_shown   = dn_ff;

   // ----------------------------------------------------------------
   // Cycle type decode
   // ----------------------------------------------------------------
   // The upper pair alone names the two wide transparent types, so
   // those are tested first; the lower pair is then address data.
   always_comb
   begin
      if (bus.cl[3:2] == dtb_pkg::CLHI_TR_A64)
      begin
         typ_dec = dtb_pkg::CYC_TR_A64;
      end
      else if (bus.cl[3:2] == dtb_pkg::CLHI_TR_VME)
      begin
         typ_dec = dtb_pkg::CYC_TR_VME;
      end
      else
      begin
         case (bus.cl)
            dtb_pkg::CL_TR_BLA:  typ_dec = dtb_pkg::CYC_TR_BLA;
            dtb_pkg::CL_IACK:    typ_dec = dtb_pkg::CYC_IACK;
            dtb_pkg::CL_DIR_C:   typ_dec = dtb_pkg::CYC_DIR_C;
            dtb_pkg::CL_DIR_NC1: typ_dec = dtb_pkg::CYC_DIR_NC1;
            dtb_pkg::CL_DIR_NC2: typ_dec = dtb_pkg::CYC_DIR_NC2;
            default:             typ_dec = dtb_pkg::CYC_RSVD;
         endcase
      end
      // Second non-compelled type cannot reach several slaves at once
      bc_able = (typ_dec != dtb_pkg::CYC_DIR_NC2) && (typ_dec != dtb_pkg::CYC_IACK) &&
                (typ_dec != dtb_pkg::CYC_RSVD);
      is_direct = (typ_ff == dtb_pkg::CYC_DIR_C) || (typ_ff == dtb_pkg::CYC_DIR_NC1) ||
                  (typ_ff == dtb_pkg::CYC_DIR_NC2);
   end

   // ----------------------------------------------------------------
   // Phase tracker and field capture
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_st     = st_ff;
      nxt_typ    = typ_ff;
      nxt_num    = num_ff;
      nxt_single = single_ff;
      nxt_bcast  = bcast_ff;
      nxt_wa     = wa_ff;
      nxt_ae     = ae_ff;
      nxt_rs     = rs_ff;
      nxt_blt    = blt_ff;
      nxt_wr     = wr_ff;
      nxt_dsel   = dsel_ff;
      nxt_apd    = 1'b0;
      nxt_dpd    = 1'b0;
      // Switches are only taken between cycles, so a change never
      // splits one cycle across two numbers.
      nxt_dn     = (st_ff == S_IDLE) ? dn_switch : dn_ff;
      case (st_ff)
         S_IDLE:
         begin
            if (bus.ap_stb)
            begin
               nxt_typ = typ_dec;
               nxt_num = bus.id;
               nxt_apd = 1'b1;
               // Optional block remap of the top address bits
               nxt_wa  = bus.ad[31:2];
               if (map_en)
               begin
                  nxt_wa[29:22] = map_base;
               end
               // Upper extension bits only exist on the wide types
               nxt_ae  = ((typ_dec == dtb_pkg::CYC_TR_A64) || (typ_dec == dtb_pkg::CYC_TR_VME)) ?
                         {bus.cl[1:0], 4'h0} : dtb_pkg::AE_RST;
               // Acknowledge carries an interrupter number, never a selection
               nxt_single = (typ_dec != dtb_pkg::CYC_IACK) && (typ_dec != dtb_pkg::CYC_RSVD) &&
                            (bus.id != dtb_pkg::DN_BCAST) && (bus.id == dn_ff);
               nxt_bcast  = (bus.id == dtb_pkg::DN_BCAST) && bc_able && bcast_en;
               if (bus.cyc_end)
               begin
                  nxt_st = S_IDLE;
               end
               else if (nxt_single || nxt_bcast)
               begin
                  nxt_st = S_SEL;
               end
               else
               begin
                  nxt_st = S_SKIP;
               end
            end
         end
         S_SEL:
         begin
            if (bus.dp_stb)
            begin
               nxt_dpd  = 1'b1;
               nxt_blt  = (typ_ff == dtb_pkg::CYC_IACK) ? 1'b0 : bus.cl[dtb_pkg::CL_BLT_BIT];
               nxt_dsel = bus.cl[dtb_pkg::CL_DSEL_HI:0];
               case (typ_ff)
                  dtb_pkg::CYC_DIR_NC1: nxt_wr = 1'b1;
                  dtb_pkg::CYC_IACK:    nxt_wr = 1'b0;
                  default:              nxt_wr = bus.cl[dtb_pkg::CL_WR_BIT];
               endcase
               if (is_direct)
               begin
                  nxt_rs = bus.id;
               end
               else if (typ_ff != dtb_pkg::CYC_IACK)
               begin
                  // ID4 is ignored whatever it holds
                  nxt_ae = {ae_ff[5:4], bus.id[3:0]};
               end
            end
            if (bus.cyc_end)
            begin
               nxt_st     = S_IDLE;
               nxt_single = 1'b0;
               nxt_bcast  = 1'b0;
            end
         end
         S_SKIP:
         begin
            // Spied traffic is not decoded further
            if (bus.cyc_end)
            begin
               nxt_st = S_IDLE;
            end
         end
         default:
         begin
            nxt_st = S_IDLE;
         end
      endcase
   end

   // Register stage only
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_ff     <= S_IDLE;
         typ_ff    <= dtb_pkg::CYC_RSVD;
         num_ff    <= dtb_pkg::ID_RST;
         single_ff <= 1'b0;
         bcast_ff  <= 1'b0;
         wa_ff     <= dtb_pkg::WA_RST;
         ae_ff     <= dtb_pkg::AE_RST;
         rs_ff     <= dtb_pkg::ID_RST;
         blt_ff    <= 1'b0;
         wr_ff     <= 1'b0;
         dsel_ff   <= 2'h0;
         apd_ff    <= 1'b0;
         dpd_ff    <= 1'b0;
         dn_ff     <= dtb_pkg::ID_RST;
      end
      else
      begin
         st_ff     <= nxt_st;
         typ_ff    <= nxt_typ;
         num_ff    <= nxt_num;
         single_ff <= nxt_single;
         bcast_ff  <= nxt_bcast;
         wa_ff     <= nxt_wa;
         ae_ff     <= nxt_ae;
         rs_ff     <= nxt_rs;
         blt_ff    <= nxt_blt;
         wr_ff     <= nxt_wr;
         dsel_ff   <= nxt_dsel;
         apd_ff    <= nxt_apd;
         dpd_ff    <= nxt_dpd;
         dn_ff     <= nxt_dn;
      end
   end

endmodule

// File: testbench/dtb_phase_field_decoder_sva.sv
module dtb_phase_field_decoder_sva
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // Information lines and phase strobes
   input  wire logic [31:0] ad,
   input  wire logic [3:0]  cl,
   input  wire logic [4:0]  id,
   input  wire logic        ap_stb,
   input  wire logic        dp_stb,
   input  wire logic        cyc_end
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   // ----------------------------------------------------------------
   // Phase sequences
   // ----------------------------------------------------------------
   sequence s_addr;
      ap_stb;
   endsequence
   sequence s_data;
      dp_stb && cyc_end;
   endsequence
   // One transfer follows each address phase, and ends the cycle
   property p_walk;
      s_addr |=> s_data;
   endproperty
   a_walk: assert property (p_walk) else $error("no data transfer after address phase");
   // Reserved codes are never issued
   property p_no_rsvd;
      s_addr |-> !(cl inside {4'h5, 4'h6, 4'hB});
   endproperty
   a_no_rsvd: assert property (p_no_rsvd) else $error("reserved cycle code issued");
   // Number zero never carries the pipelined non-compelled type
   property p_bcast_nc2;
      s_addr and (id == 5'h00) |-> cl != 4'hA;
   endproperty
   a_bcast_nc2: assert property (p_bcast_nc2) else $error("number zero with non-broadcast type");
   // Non-compelled one is always a write
   property p_nc1_wr;
      s_addr and (cl == 4'h9) |=> s_data and cl[2];
   endproperty
   a_nc1_wr: assert property (p_nc1_wr) else $error("non-compelled one not a write");
   // Acknowledge data phase: read, reserved lines quiet
   property p_iack_dp;
      s_addr and (cl == 4'h7) |=> cl[3:2] == 2'h0 && id == 5'h00;
   endproperty
   a_iack_dp: assert property (p_iack_dp) else $error("acknowledge data phase fields wrong");
   // Transparent data phase leaves the top ident line clear
   property p_tr_id4;
      s_addr and (cl[3:2] != 2'h2) and (cl != 4'h7) |=> !id[4];
   endproperty
   a_tr_id4: assert property (p_tr_id4) else $error("reserved ident line set");
   // Word address only: low two lines clear
   property p_word;
      s_addr |-> ad[1:0] == 2'h0;
   endproperty
   a_word: assert property (p_word) else $error("address not word aligned");
   // A data transfer only ever follows an address phase
   property p_dp_order;
      dp_stb |-> $past(ap_stb);
   endproperty
   a_dp_order: assert property (p_dp_order) else $error("data transfer without address phase");
endmodule

// File: testbench/dtb_phase_field_decoder_tb_top.sv
module dtb_phase_field_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic          core_clk, arst_n, req_valid, req_ready, req_err, req_blt, req_write;
   dtb_pkg::cyc_t req_type, cyc_type;
   logic [4:0]    req_num, req_rs, num, rs, dn_switch, dn_shown;
   logic [29:0]   req_waddr, word_addr;
   logic [5:0]    req_ae, ae;
   logic [1:0]    req_dsel, dsel;
   logic [7:0]    map_base;
   logic          bcast_en, map_en, ap_done, sel_single, sel_bcast, selected, dp_done, blt, write;
   int            n_mismatch, n_compared;
   dtb_if u_dtb_if ();
   dtb_master_encoder u_dtb_master_encoder (.core_clk(core_clk), .arst_n(arst_n), .req_valid(req_valid),
      .req_ready(req_ready), .req_type(req_type), .req_num(req_num), .req_waddr(req_waddr), .req_ae(req_ae),
      .req_rs(req_rs), .req_blt(req_blt), .req_write(req_write), .req_dsel(req_dsel), .req_err(req_err),
      .bus(u_dtb_if.master));
   dtb_slave_decoder u_dtb_slave_decoder (.core_clk(core_clk), .arst_n(arst_n), .dn_switch(dn_switch),
      .bcast_en(bcast_en), .map_en(map_en), .map_base(map_base), .bus(u_dtb_if.slave), .ap_done(ap_done),
      .cyc_type(cyc_type), .num(num), .sel_single(sel_single), .sel_bcast(sel_bcast), .selected(selected),
      .word_addr(word_addr), .dp_done(dp_done), .ae(ae), .rs(rs), .blt(blt), .write(write), .dsel(dsel),
      .dn_shown(dn_shown));
   dtb_phase_field_decoder_sva u_sva (.core_clk(core_clk), .arst_n(arst_n), .ad(u_dtb_if.ad),
      .cl(u_dtb_if.cl), .id(u_dtb_if.id), .ap_stb(u_dtb_if.ap_stb), .dp_stb(u_dtb_if.dp_stb),
      .cyc_end(u_dtb_if.cyc_end));
   // Free-running 100 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ----------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Selection outcome; acknowledge carries an interrupter number and never selects
   function automatic logic exp_sel(input dtb_pkg::cyc_t t, input logic [4:0] n);
      if (t == dtb_pkg::CYC_IACK || t == dtb_pkg::CYC_RSVD)
         return 1'b0;
      if (n == 5'h00)
         return bcast_en && t != dtb_pkg::CYC_DIR_NC2;
      return n == dn_switch;
   endfunction
   task automatic complete_run();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // One request through both ends
   // ----------------------------------------------------------------
   task automatic do_req(input dtb_pkg::cyc_t t, input logic [4:0] n);
      logic       legal, sel, drct, tr;
      logic [5:0] exp_ae;
      int         k;
      {req_waddr, req_ae, req_rs, req_blt, req_write, req_dsel} = 45'({$urandom, $urandom});
      req_type = t;
      req_num = n;
      legal = !(t == dtb_pkg::CYC_RSVD || (n == 5'h00 && (t == dtb_pkg::CYC_DIR_NC2 ||
              (t == dtb_pkg::CYC_DIR_NC1 && !req_write))));
      sel = exp_sel(t, n);
      drct = t inside {dtb_pkg::CYC_DIR_C, dtb_pkg::CYC_DIR_NC1, dtb_pkg::CYC_DIR_NC2};
      tr = t inside {dtb_pkg::CYC_TR_A64, dtb_pkg::CYC_TR_VME};
      exp_ae = tr ? req_ae : {2'h0, req_ae[3:0]};
      req_valid = 1'b1;
      @(posedge core_clk);
      #1 req_valid = 1'b0;
      check(req_ready, !legal);
      // Bounded wait for either outcome
      for (k = 0; k < 6 && ap_done !== 1'b1 && req_err !== 1'b1; k++)
      begin
         @(posedge core_clk);
         #1;
      end
      if (ap_done !== 1'b1 && req_err !== 1'b1)
      begin
         // Neither outcome within the bound: give up and report
         $display("ERROR %0t wait bound used up", $time);
         n_mismatch++;
         complete_run();
      end
      else if (!legal)
      begin
         check(req_err, 1'b1);
         // Let an edge pass so the next request never meets a fresh release
         @(posedge core_clk);
         #1;
         check({req_err, ap_done, u_dtb_if.ap_stb}, 3'h0);
      end
      else
      begin
         check({ap_done, cyc_type, num}, {1'b1, t, n});
         check(word_addr, map_en ? {map_base, req_waddr[21:0]} : req_waddr);
         check({selected, sel_bcast, sel_single}, {sel, sel && n == 5'h00, sel && n != 5'h00});
         check({u_dtb_if.cl, u_dtb_if.id}, {req_blt && t != dtb_pkg::CYC_IACK,
            (req_write || t == dtb_pkg::CYC_DIR_NC1) && t != dtb_pkg::CYC_IACK, req_dsel,
            drct ? req_rs : (t == dtb_pkg::CYC_IACK ? 5'h00 : {1'b0, req_ae[3:0]})});
         @(posedge core_clk);
         #1;
         check({dp_done, selected}, {sel, 1'b0});
         if (sel)
         begin
            check({blt, write, dsel}, {req_blt, req_write || t == dtb_pkg::CYC_DIR_NC1, req_dsel});
            if (drct)
               check(rs, req_rs);
            else
               check(ae, exp_ae);
         end
      end
   endtask
   // ----------------------------------------------------------------
   // Main sequence: corner numbers 1 and 31, then random numbers
   // ----------------------------------------------------------------
   initial
   begin
      {req_valid, req_num, req_waddr, req_ae, req_rs, req_blt, req_write, req_dsel} = '0;
      req_type = dtb_pkg::CYC_TR_A64;
      {dn_switch, bcast_en, map_en, map_base, n_mismatch, n_compared} = '0;
      arst_n = 1'b0;
      void'($urandom(8));
      repeat (2) @(posedge core_clk);
      #1 arst_n = 1'b1;
      for (int b = 0; b < 10; b++)
      begin
         // Switch changes only between cycles, while idle
         dn_switch = (b == 0) ? 5'h01 : (b == 1) ? 5'h1F : 5'($urandom_range(31, 1));
         {bcast_en, map_en, map_base} = 10'($urandom);
         repeat (2) @(posedge core_clk);
         #1 check(dn_shown, dn_switch);
         for (int t = 0; t < 8; t++)
         begin
            do_req(dtb_pkg::cyc_t'(t), dn_switch);
            do_req(dtb_pkg::cyc_t'(t), 5'h00);
            do_req(dtb_pkg::cyc_t'(t), ~dn_switch);
         end
         repeat (30) do_req(dtb_pkg::cyc_t'($urandom_range(7)), ($urandom_range(2) == 0) ? 5'h00 : 5'($urandom));
      end
      complete_run();
   end
endmodule
